/* File: atsm_mapper.sv */
// Operation
// - Mode 1: six lanes, 16 bits each, two 12-bit samples per channel split.
// - Mode 2: one 8-bit octet per lane, lanes 0-3 carry A0..D0.
// - Mode 3: five octets per lane, four 10-bit samples, one channel per lane.
// - Mode 4: three lanes of 16 bits packing A0,B0,C0,D0 back to back.
// - Mode 5: two lanes, lane 0 A0 then B0, lane 1 C0 then D0.
// - Mode 6: same six-lane 12-bit layout as mode 1.
// - Mode 7: one 8-bit octet per lane, lanes 0-3 carry A0..D0.
// - Mode 8: three octets per lane, two 12-bit samples, one channel per lane.
// - Mode 9: eight lanes, one octet each, channel pairs of samples 0 and 1.
// - Mode 10: eight lanes, even lane even samples, odd lane odd samples.
// - Tail and unused bits are zero; samples go MSB first.
// - Lowest lanes are used, higher unused lanes are powered down.
// - Sample index n orders samples of a channel by time within a frame.
`timescale 1ns/100ps
`include "atsm_map.svh"
module atsm_mapper (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic link_reinit,
  input wire logic [3:0] transport_mode_select,
  input wire logic frame_valid,
  output logic frame_ready,
  input wire logic [`ATSM_NCH*`ATSM_NSMP*`ATSM_SMP_W-1:0] frame_samples,
  output logic lane_valid,
  input wire logic lane_ready,
  output logic [`ATSM_NLANE*`ATSM_LANE_W-1:0] lane_data,
  output logic [`ATSM_NLANE-1:0] lane_power_en,
  output logic [2:0] lane_octets,
  output logic mode_ok
);
  localparam int LW = `ATSM_LANE_W;

  atsm_pkg::atsm_map_state_t st_q;
  atsm_pkg::atsm_map_state_t st_d;
  logic [`ATSM_SMP_W-1:0] smp [`ATSM_NCH][`ATSM_NSMP];
  logic [`ATSM_NLANE*`ATSM_LANE_W-1:0] packed_w;
  logic fifo_in_ready;
  logic push;
  logic [3:0] nlanes;

  // Channel c sample n, n ordered by time within the frame
  for (genvar g = 0; g < `ATSM_NCH * `ATSM_NSMP; g++) begin : g_smp
    assign smp[g / `ATSM_NSMP][g % `ATSM_NSMP] =
      frame_samples[g*`ATSM_SMP_W +: `ATSM_SMP_W];
  end

  always_comb begin
    st_d = st_q;
    if (link_reinit) begin
      if (transport_mode_select >= 4'h1 && transport_mode_select <= 4'hA) begin
        st_d.mode = atsm_pkg::atsm_mode_t'(transport_mode_select);
      end else begin
        st_d.mode = atsm_pkg::ATSM_MODE_NONE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q.mode <= atsm_pkg::atsm_mode_t'(`ATSM_MODE_RST);
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Octet 0 sits in the top byte of each 40-bit lane word
  always_comb begin
    packed_w = '0;
    case (st_q.mode)
      atsm_pkg::ATSM_M1, atsm_pkg::ATSM_M6: begin
        for (int k = 0; k < 2; k++) begin
          packed_w[(3*k)*LW+24 +: 16] =
            {smp[2*k][0], smp[2*k][1][11:8]};
          packed_w[(3*k+1)*LW+24 +: 16] =
            {smp[2*k][1][7:0], smp[2*k+1][0][11:4]};
          packed_w[(3*k+2)*LW+24 +: 16] =
            {smp[2*k+1][0][3:0], smp[2*k+1][1]};
        end
      end
      atsm_pkg::ATSM_M2, atsm_pkg::ATSM_M7: begin
        for (int c = 0; c < 4; c++) begin
          packed_w[c*LW+32 +: 8] = smp[c][0][7:0];
        end
      end
      atsm_pkg::ATSM_M3: begin
        for (int c = 0; c < 4; c++) begin
          packed_w[c*LW +: 40] = {smp[c][0][9:0], smp[c][1][9:0],
            smp[c][2][9:0], smp[c][3][9:0]};
        end
      end
      atsm_pkg::ATSM_M4: begin
        packed_w[0*LW+24 +: 16] = {smp[0][0], smp[1][0][11:8]};
        packed_w[1*LW+24 +: 16] = {smp[1][0][7:0], smp[2][0][11:4]};
        packed_w[2*LW+24 +: 16] = {smp[2][0][3:0], smp[3][0]};
      end
      atsm_pkg::ATSM_M5: begin
        packed_w[0*LW+24 +: 16] = {smp[0][0][7:0], smp[1][0][7:0]};
        packed_w[1*LW+24 +: 16] = {smp[2][0][7:0], smp[3][0][7:0]};
      end
      atsm_pkg::ATSM_M8: begin
        for (int c = 0; c < 4; c++) begin
          packed_w[c*LW+16 +: 24] = {smp[c][0], smp[c][1]};
        end
      end
      atsm_pkg::ATSM_M9: begin
        for (int c = 0; c < 4; c++) begin
          for (int i = 0; i < 2; i++) begin
            packed_w[(2*c+i)*LW+32 +: 8] = smp[c][i][7:0];
          end
        end
      end
      atsm_pkg::ATSM_M10: begin
        for (int c = 0; c < 4; c++) begin
          for (int i = 0; i < 2; i++) begin
            packed_w[(2*c+i)*LW +: 40] = {smp[c][i][9:0],
              smp[c][i+2][9:0], smp[c][i+4][9:0],
              smp[c][i+6][9:0]};
          end
        end
      end
      default: begin
        packed_w = '0;
      end
    endcase
  end

  always_comb begin
    case (st_q.mode)
      atsm_pkg::ATSM_M1, atsm_pkg::ATSM_M6: begin
        nlanes = 4'h6;
        lane_octets = 3'h2;
      end
      atsm_pkg::ATSM_M2, atsm_pkg::ATSM_M7: begin
        nlanes = 4'h4;
        lane_octets = 3'h1;
      end
      atsm_pkg::ATSM_M3: begin
        nlanes = 4'h4;
        lane_octets = 3'h5;
      end
      atsm_pkg::ATSM_M4: begin
        nlanes = 4'h3;
        lane_octets = 3'h2;
      end
      atsm_pkg::ATSM_M5: begin
        nlanes = 4'h2;
        lane_octets = 3'h2;
      end
      atsm_pkg::ATSM_M8: begin
        nlanes = 4'h4;
        lane_octets = 3'h3;
      end
      atsm_pkg::ATSM_M9: begin
        nlanes = 4'h8;
        lane_octets = 3'h1;
      end
      atsm_pkg::ATSM_M10: begin
        nlanes = 4'h8;
        lane_octets = 3'h5;
      end
      default: begin
        nlanes = 4'h0;
        lane_octets = 3'h0;
      end
    endcase
  end

  for (genvar l = 0; l < `ATSM_NLANE; l++) begin : g_pwr
    assign lane_power_en[l] = (4'(l) < nlanes);
  end

  assign mode_ok = (st_q.mode != atsm_pkg::ATSM_MODE_NONE);
  // Frames are swallowed while no valid mode is latched
  assign frame_ready = mode_ok ? (fifo_in_ready && !link_reinit) : 1'b1;
  assign push = frame_valid && mode_ok && !link_reinit;

  atsm_fifo #(
    .W(`ATSM_NLANE*`ATSM_LANE_W),
    .D(`ATSM_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .flush(link_reinit),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(packed_w),
    .out_valid(lane_valid),
    .out_ready(lane_ready),
    .out_data(lane_data)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  a_mode_held_run: assert property (
    ce && !link_reinit |=> $stable(st_q.mode))
    else $error("mode changed without reinit");
  a_mode_take_reinit: assert property (
    ce && link_reinit && transport_mode_select == 4'h4
    |=> st_q.mode == atsm_pkg::ATSM_M4)
    else $error("mode not taken at reinit");
  a_m1_lane_split: assert property (
    st_q.mode == atsm_pkg::ATSM_M1 |->
    packed_w[LW+24 +: 16] == {smp[0][1][7:0], smp[1][0][11:4]})
    else $error("mode 1 lane 1 wrong");
  a_m2_lane_octet: assert property (
    st_q.mode == atsm_pkg::ATSM_M2 |->
    packed_w[3*LW+32 +: 8] == smp[3][0][7:0] && packed_w[3*LW +: 32] == '0)
    else $error("mode 2 lane 3 wrong");
  a_m3_lane_pack: assert property (
    st_q.mode == atsm_pkg::ATSM_M3 |->
    packed_w[2*LW +: 10] == smp[2][3][9:0])
    else $error("mode 3 last sample wrong");
  a_m4_lane_tail: assert property (
    st_q.mode == atsm_pkg::ATSM_M4 |->
    packed_w[2*LW+24 +: 16] == {smp[2][0][3:0], smp[3][0]})
    else $error("mode 4 lane 2 wrong");
  a_m8_lane_pair: assert property (
    st_q.mode == atsm_pkg::ATSM_M8 |->
    packed_w[LW+16 +: 24] == {smp[1][0], smp[1][1]})
    else $error("mode 8 lane 1 wrong");
  a_m10_odd_lane: assert property (
    st_q.mode == atsm_pkg::ATSM_M10 |->
    packed_w[7*LW+30 +: 10] == smp[3][1][9:0])
    else $error("mode 10 odd lane wrong");
  a_unused_lanes_zero: assert property (
    st_q.mode == atsm_pkg::ATSM_M5 |-> packed_w[8*LW-1:2*LW] == '0)
    else $error("unused lane not zero");
  a_lane_power_map: assert property (
    st_q.mode == atsm_pkg::ATSM_M4 |-> lane_power_en == 8'h07)
    else $error("lane power mask wrong");

  c_frame_push: cover property (push && fifo_in_ready);
  c_fifo_full: cover property (mode_ok && !fifo_in_ready);
  c_mode10_out: cover property (
    st_q.mode == atsm_pkg::ATSM_M10 && lane_valid && lane_ready);
endmodule

/* File: atsm_map.svh */
`ifndef ATSM_MAP_SVH
`define ATSM_MAP_SVH

`define ATSM_NCH 4
`define ATSM_NSMP 8
`define ATSM_SMP_W 12
`define ATSM_NLANE 8
`define ATSM_LANE_W 40
`define ATSM_FIFO_DEPTH 8
`define ATSM_MODE_RST 4'h2

`endif

/* File: atsm_pkg.sv */
package atsm_pkg;

  typedef enum logic [3:0] {
    ATSM_MODE_NONE = 4'h0,
    ATSM_M1 = 4'h1,
    ATSM_M2 = 4'h2,
    ATSM_M3 = 4'h3,
    ATSM_M4 = 4'h4,
    ATSM_M5 = 4'h5,
    ATSM_M6 = 4'h6,
    ATSM_M7 = 4'h7,
    ATSM_M8 = 4'h8,
    ATSM_M9 = 4'h9,
    ATSM_M10 = 4'hA
  } atsm_mode_t;

  typedef struct packed {
    atsm_mode_t mode;
  } atsm_map_state_t;

endpackage

/* File: atsm_fifo.sv */
`timescale 1ns/100ps
module atsm_fifo #(
  parameter int W = 320,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] cnt;
  } atsm_fifo_state_t;

  atsm_fifo_state_t st_q;
  atsm_fifo_state_t st_d;
  logic push;
  logic pop;

  assign in_ready = (st_q.cnt != CW'(D));
  assign out_valid = (st_q.cnt != '0);
  assign out_data = st_q.mem[st_q.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (flush) begin
      st_d.wptr = '0;
      st_d.rptr = '0;
      st_d.cnt = '0;
    end else begin
      if (push) begin
        st_d.mem[st_q.wptr] = in_data;
        st_d.wptr = (st_q.wptr == AW'(D - 1)) ? '0 : AW'(st_q.wptr + 1'b1);
      end
      if (pop) begin
        st_d.rptr = (st_q.rptr == AW'(D - 1)) ? '0 : AW'(st_q.rptr + 1'b1);
      end
      if (push && !pop) begin
        st_d.cnt = CW'(st_q.cnt + 1'b1);
      end else if (pop && !push) begin
        st_d.cnt = CW'(st_q.cnt - 1'b1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end
endmodule

/* File: atsm_lane_sink.sv */
`timescale 1ns/100ps
module atsm_lane_sink (
  input wire logic clock,
  input wire logic srst,
  input wire logic stop,
  input wire logic slow,
  input wire logic lane_valid,
  output logic lane_ready,
  input wire logic [319:0] lane_data
);
  logic [319:0] q[$];
  logic tog_q;
  // Slow receiver takes every other cycle
  assign lane_ready = !stop && (!slow || tog_q);
  always @(posedge clock) begin
    tog_q <= srst ? 1'b0 : !tog_q;
    if (!srst && lane_valid && lane_ready) begin
      q.push_back(lane_data);
    end
  end
endmodule

/* File: adc_transport_sample_mapper_test.sv */
`timescale 1ns/100ps
module adc_transport_sample_mapper_test;
  typedef struct packed {
    logic [3:0] m;
    logic [7:0] p;
    logic [2:0] o;
  } atsm_row_t;
  logic clock = 0, srst = 1, ce = 1, link_reinit = 0, frame_valid = 0;
  logic stop = 0, slow = 0;
  logic [3:0] transport_mode_select = 4'h0;
  logic [3:0] cur = 4'h2;
  logic [383:0] frame_samples = '0;
  logic frame_ready, lane_valid, lane_ready, mode_ok;
  logic [319:0] lane_data;
  logic [7:0] lane_power_en;
  logic [2:0] lane_octets;
  logic [319:0] exp_q[$];
  int fail_count = 0, checks = 0, cyc = 0;
  atsm_row_t rows[12] = '{'{4'h1, 8'h3F, 3'h2}, '{4'h2, 8'h0F, 3'h1},
    '{4'h3, 8'h0F, 3'h5}, '{4'h4, 8'h07, 3'h2}, '{4'h5, 8'h03, 3'h2},
    '{4'h6, 8'h3F, 3'h2}, '{4'h7, 8'h0F, 3'h1}, '{4'h8, 8'h0F, 3'h3},
    '{4'h9, 8'hFF, 3'h1}, '{4'hA, 8'hFF, 3'h5}, '{4'h0, 8'h00, 3'h0},
    '{4'hB, 8'h00, 3'h0}};

  atsm_mapper u_atsm_mapper (.clock, .srst, .ce, .link_reinit,
    .transport_mode_select, .frame_valid, .frame_ready, .frame_samples,
    .lane_valid, .lane_ready, .lane_data, .lane_power_en, .lane_octets,
    .mode_ok);
  atsm_lane_sink u_atsm_lane_sink (.clock, .srst, .stop, .slow,
    .lane_valid, .lane_ready, .lane_data);

  always #10 clock = ~clock;

  function automatic logic [319:0] pk(logic [3:0] m, logic [383:0] s);
    logic [47:0] t;
    logic [11:0] v;
    pk = '0;
    for (int c = 0; c < 4; c++) begin
      for (int n = 0; n < 8; n++) begin
        v = s[(c*8+n)*12 +: 12];
        case (m)
          4'h2, 4'h7: if (n == 0) pk[c*40+32 +: 8] = v[7:0];
          4'h3: if (n < 4) pk[c*40+30-10*n +: 10] = v[9:0];
          4'h5: if (n == 0) pk[(c/2)*40+32-8*(c%2) +: 8] = v[7:0];
          4'h8: if (n < 2) pk[c*40+28-12*n +: 12] = v;
          4'h9: if (n < 2) pk[(2*c+n)*40+32 +: 8] = v[7:0];
          4'hA: pk[(2*c+n%2)*40+30-10*(n/2) +: 10] = v[9:0];
          default: ;
        endcase
      end
    end
    // 48-bit sample runs cut into 16-bit lane slices
    for (int h = 0; h < 2; h++) begin
      t = (m == 4'h4) ? {s[11:0], s[107:96], s[203:192], s[299:288]} :
        {s[h*192 +: 12], s[h*192+12 +: 12], s[h*192+96 +: 12],
        s[h*192+108 +: 12]};
      if (m == 4'h1 || m == 4'h6 || (m == 4'h4 && h == 0)) begin
        for (int k = 0; k < 3; k++) pk[(3*h+k)*40+24 +: 16] = t[47-16*k -: 16];
      end
    end
  endfunction

  task automatic chk(logic [319:0] g, logic [319:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t value differs", $time);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic rst_chk();
    chk({lane_valid, frame_ready}, 320'(2'b01));
    chk({lane_power_en, lane_octets, mode_ok}, {8'h0F, 3'h1, 1'b1});
  endtask

  task automatic reinit(logic [3:0] m);
    link_reinit = 1;
    transport_mode_select = m;
    @(negedge clock);
    link_reinit = 0;
    @(negedge clock);
  endtask

  task automatic push(int k);
    for (int i = 0; i < 32; i++) begin
      frame_samples[i*12 +: 12] = 12'(i * 157 + k * 59) ^ 12'h3A1;
    end
    frame_valid = 1;
    while (!frame_ready) @(negedge clock);
    if (cur inside {[1:10]}) exp_q.push_back(pk(cur, frame_samples));
    @(negedge clock);
  endtask

  task automatic drain();
    stop = 0;
    while (lane_valid) @(negedge clock);
    chk(320'(u_atsm_lane_sink.q.size()), 320'(exp_q.size()));
    while (exp_q.size() > 0 && u_atsm_lane_sink.q.size() > 0) begin
      chk(u_atsm_lane_sink.q.pop_front(), exp_q.pop_front());
    end
    u_atsm_lane_sink.q.delete();
    exp_q.delete();
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(negedge clock);
    srst = 0;
    rst_chk();
    transport_mode_select = 4'h4;
    push(99);
    frame_valid = 0;
    drain();
    foreach (rows[r]) begin
      reinit(rows[r].m);
      cur = rows[r].m;
      chk({lane_power_en, lane_octets, mode_ok},
        {rows[r].p, rows[r].o, 1'(rows[r].m inside {[1:10]})});
      slow = r[0];
      push(2 * r);
      push(2 * r + 1);
      frame_valid = 0;
      drain();
    end
    reinit(4'h3);
    cur = 4'h3;
    stop = 1;
    for (int i = 0; i < 8; i++) push(40 + i);
    frame_valid = 0;
    chk(320'(frame_ready), 320'(0));
    drain();
    link_reinit = 1;
    @(negedge clock);
    chk(320'(frame_ready), 320'(0));
    link_reinit = 0;
    stop = 1;
    push(60);
    push(61);
    frame_valid = 0;
    reinit(4'h3);
    exp_q.delete();
    drain();
    // Clock enable low: a reinit pulse must not load the new mode
    ce = 0;
    reinit(4'h4);
    chk(320'(lane_octets), 320'(3'h5));
    ce = 1;
    // Reset in mid-run with a word still queued
    stop = 1;
    push(70);
    frame_valid = 0;
    srst = 1;
    repeat (2) @(negedge clock);
    srst = 0;
    rst_chk();
    exp_q.delete();
    drain();
    test_done();
  end
endmodule
